// >>> src/stage_irq_ctrl.sv
// Stage completion enable, low-limit flags and active-low interrupt output.
`timescale 1ns/1ps
module stage_irq_ctrl
    import stage_irq_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [NUM_STAGES-1:0] STAGE_DONE_IN,
    input wire logic [NUM_STAGES-1:0] STAGE_LOW_EXCEED_IN,
    input wire logic [NUM_STAGES-1:0] LOW_ENABLE_IN,
    input wire logic GPIO_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [DATA_W-1:0] REG_WDATA_IN,
    output logic [DATA_W-1:0] REG_RDATA_OUT,
    output logic INT_N_OUT
);

    reg_req_type req;
    logic gpio_change;
    logic [DONE_EN_W-1:0] en_reg;
    logic [DONE_EN_W-1:0] en_next;
    logic [NUM_STAGES-1:0] done_pend_reg;
    logic [NUM_STAGES-1:0] done_pend_next;
    logic gpio_pend_reg;
    logic gpio_pend_next;
    logic [NUM_STAGES-1:0] low_flags_reg;
    logic [NUM_STAGES-1:0] low_flags_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic int_n_reg;
    logic int_n_next;
    logic rd_low;
    logic rd_status;
    logic wr_en;
    logic [NUM_STAGES-1:0] low_set;
    logic int_src;

    function automatic logic hit(input reg_req_type r, input logic [ADDR_W-1:0] off);
        return r.addr == off;
    endfunction

    assign req = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN, wdata: REG_WDATA_IN};

    level_change_detect gpio_sync
    (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .pin_in(GPIO_IN),
        .change_out(gpio_change)
    );

    // Enable register: only a write to its own offset changes it.
    always_comb
    begin
        wr_en = req.wr && hit(req, DONE_EN_OFFSET);
        // Upper bits of a write are dropped, so a careless host cannot create stray enables.
        en_next = wr_en ? req.wdata[DONE_EN_W-1:0] : en_reg;
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            en_reg <= DONE_EN_RESET;
        end
        else
        begin
            en_reg <= en_next;
        end
    end

    // Pending bits are set whatever the enables say, so enabling later still raises the line.
    always_comb
    begin
        rd_status = req.rd && hit(req, DONE_STATUS_OFFSET);
        // A completion that lands on the clearing read survives: set wins over clear.
        done_pend_next = (rd_status ? FLAGS_RESET : done_pend_reg) | STAGE_DONE_IN;
        gpio_pend_next = (rd_status ? 1'b0 : gpio_pend_reg) | gpio_change;
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            done_pend_reg <= FLAGS_RESET;
            gpio_pend_reg <= 1'b0;
        end
        else
        begin
            done_pend_reg <= done_pend_next;
            gpio_pend_reg <= gpio_pend_next;
        end
    end

    always_comb
    begin
        rd_low = req.rd && hit(req, LOW_FLAGS_OFFSET);
        low_set = STAGE_DONE_IN & STAGE_LOW_EXCEED_IN;
        low_flags_next = (rd_low ? (low_flags_reg & STAGE_LOW_EXCEED_IN) : low_flags_reg)
            | low_set;
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            low_flags_reg <= FLAGS_RESET;
        end
        else
        begin
            low_flags_reg <= low_flags_next;
        end
    end

    // Read data holds the last read value; unmapped reads return zero.
    always_comb
    begin
        rdata_next = rdata_reg;
        if (req.rd)
        begin
            rdata_next = RDATA_RESET;
            if (hit(req, DONE_EN_OFFSET))
                rdata_next[DONE_EN_W-1:0] = en_reg;
            else if (hit(req, LOW_FLAGS_OFFSET))
                rdata_next[NUM_STAGES-1:0] = low_flags_reg;
            else if (hit(req, DONE_STATUS_OFFSET))
                rdata_next[GPIO_BIT_POS:0] = {gpio_pend_reg, done_pend_reg};
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            rdata_reg <= RDATA_RESET;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    always_comb
    begin
        int_src = |(done_pend_reg & en_reg[NUM_STAGES-1:0])
            | (gpio_pend_reg & en_reg[GPIO_BIT_POS])
            | |(low_flags_reg & LOW_ENABLE_IN);
        int_n_next = ~int_src;
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            int_n_reg <= 1'b1;
        end
        else
        begin
            int_n_reg <= int_n_next;
        end
    end

    assign REG_RDATA_OUT = rdata_reg;
    assign INT_N_OUT = int_n_reg;

    chk_done_raises_int: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (|(STAGE_DONE_IN & en_reg[NUM_STAGES-1:0]) && !wr_en) |=> ##1 !INT_N_OUT)
        else $error("Enabled stage completion did not pull interrupt low.");

    chk_no_source_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (en_reg == '0 && LOW_ENABLE_IN == '0) |=> INT_N_OUT)
        else $error("Interrupt asserted while every source was disabled.");

    chk_gpio_gate: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (gpio_pend_reg && en_reg[GPIO_BIT_POS]) |=> !INT_N_OUT)
        else $error("Enabled GPIO change did not pull interrupt low.");

    chk_en_write: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        wr_en |=> en_reg == $past(REG_WDATA_IN[DONE_EN_W-1:0]))
        else $error("Enable register did not take the written value.");

    chk_low_set: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        |low_set |=> (low_flags_reg & $past(low_set)) == $past(low_set))
        else $error("Low-limit flag not set after exceeded result.");

    chk_low_readback: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        rd_low |=> REG_RDATA_OUT == {4'h0, $past(low_flags_reg)})
        else $error("Low-limit register read returned wrong data.");

    chk_low_clear: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (rd_low && !(|STAGE_LOW_EXCEED_IN)) |=> low_flags_reg == 12'h000)
        else $error("Low-limit flags did not clear on readback.");

    chk_gpio_event: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        gpio_change |=> gpio_pend_reg)
        else $error("GPIO change did not set its status flag.");

    chk_int_release: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (done_pend_reg == '0 && !gpio_pend_reg && low_flags_reg == '0) |=> INT_N_OUT)
        else $error("Interrupt not released with nothing pending.");

    chk_low_int_drive: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        |(low_flags_reg & LOW_ENABLE_IN) |=> !INT_N_OUT)
        else $error("Enabled low-limit flag did not pull interrupt low.");

    chk_gpio_blocked: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (!en_reg[GPIO_BIT_POS] && !(|(done_pend_reg & en_reg[NUM_STAGES-1:0]))
            && !(|(low_flags_reg & LOW_ENABLE_IN))) |=> INT_N_OUT)
        else $error("Disabled GPIO change pulled interrupt low.");

    chk_done_pend_set: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        |STAGE_DONE_IN |=> (done_pend_reg & $past(STAGE_DONE_IN)) == $past(STAGE_DONE_IN))
        else $error("Completion did not set its pending bit.");

    chk_status_read: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        rd_status |=> REG_RDATA_OUT == {3'h0, $past(gpio_pend_reg), $past(done_pend_reg)})
        else $error("Status register read returned wrong data.");

    chk_status_clear: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (rd_status && STAGE_DONE_IN == '0 && !gpio_change)
            |=> (done_pend_reg == '0 && !gpio_pend_reg))
        else $error("Status flags did not clear on readback.");

    chk_low_keep: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        rd_low |=> (low_flags_reg & $past(low_flags_reg) & $past(STAGE_LOW_EXCEED_IN))
            == ($past(low_flags_reg) & $past(STAGE_LOW_EXCEED_IN)))
        else $error("Low-limit flag lost on readback while its limit still held.");

    chk_low_write_ignored: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (req.wr && hit(req, LOW_FLAGS_OFFSET) && low_set == '0)
            |=> low_flags_reg == $past(low_flags_reg))
        else $error("Write changed the read-only low-limit flags.");

    chk_en_readback: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (req.rd && hit(req, DONE_EN_OFFSET)) |=> REG_RDATA_OUT == {3'h0, $past(en_reg)})
        else $error("Enable register read returned wrong data.");

    chk_reset_idle: assert property (@(posedge SYS_CLK_IN)
        !RSTN_IN |=> (INT_N_OUT && REG_RDATA_OUT == RDATA_RESET))
        else $error("Outputs not idle after reset.");

endmodule // stage_irq_ctrl

// >>> src/stage_irq_pkg.sv
// Package with register map, field layout and carrier types of the stage interrupt block.
package stage_irq_pkg;

    localparam int NUM_STAGES = 12;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] DONE_EN_OFFSET = 12'h007;
    localparam logic [ADDR_W-1:0] LOW_FLAGS_OFFSET = 12'h008;
    localparam logic [ADDR_W-1:0] DONE_STATUS_OFFSET = 12'h00a;

    localparam int GPIO_BIT_POS = 12;
    localparam int DONE_EN_W = 13;

    localparam logic [DONE_EN_W-1:0] DONE_EN_RESET = 13'h0000;
    localparam logic [NUM_STAGES-1:0] FLAGS_RESET = 12'h000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_type;

endpackage

// >>> src/level_change_detect.sv
// Two-stage synchroniser for an outside pin with a level-change pulse.
`timescale 1ns/1ps
module level_change_detect
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    output logic change_out
);

    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    logic last_reg;
    logic last_next;
    logic [2:0] fill_reg;
    logic [2:0] fill_next;

    // Only the second stage and later feed the comparator, never the metastable first stage.
    always_comb
    begin
        meta_next = pin_in;
        sync_next = meta_reg;
        last_next = sync_reg;
        fill_next = {fill_reg[1:0], 1'b1};
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            fill_reg <= 3'h0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
            fill_reg <= fill_next;
        end
    end

    // The stages reset to zero, not to the pin's level, so a pin idling high would look
    // like a change; the output stays masked until all three stages hold real samples.
    // A genuine change between the first two real samples is still reported, as that is the first unmasked compare.
    assign change_out = (sync_reg ^ last_reg) & fill_reg[2];

endmodule // level_change_detect

// >>> sim/host_model.sv
// Host model that drives the register strobes of the interrupt block.
`timescale 1ns/1ps
module host_model
    import stage_irq_pkg::*;
(
    input wire logic clk_in,
    input wire logic [DATA_W-1:0] rdata_in,
    output reg_req_type req_out
);
    initial req_out = '0;
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge clk_in);
        req_out <= '{wr: wr, rd: !wr, addr: a, wdata: d & 16'h1fff};
        @(posedge clk_in);
        req_out <= '0;
        #1 q = rdata_in;
    endtask
endmodule // host_model

// >>> sim/stage_irq_ctrl_tb_top.sv
// Self-checking bench for the stage interrupt block.
`timescale 1ns/1ps
module stage_irq_ctrl_tb_top;
    import stage_irq_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [NUM_STAGES-1:0] done = '0;
    logic [NUM_STAGES-1:0] exceed = '0;
    logic [NUM_STAGES-1:0] low_en = '0;
    logic gpio = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] q;
    logic int_n;
    reg_req_type req;
    int errors = 0;
    int total_checks = 0;
    always #12.5 clk = ~clk;
    host_model u_host (.clk_in(clk), .rdata_in(rdata), .req_out(req));
    stage_irq_ctrl u_dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .STAGE_DONE_IN(done),
        .STAGE_LOW_EXCEED_IN(exceed), .LOW_ENABLE_IN(low_en), .GPIO_IN(gpio),
        .REG_WR_IN(req.wr), .REG_RD_IN(req.rd), .REG_ADDR_IN(req.addr),
        .REG_WDATA_IN(req.wdata), .REG_RDATA_OUT(rdata), .INT_N_OUT(int_n));
    task automatic check(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] a);
        total_checks++;
        if (a !== e)
        begin
            errors++;
            $display("[FAIL] t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    task automatic ck_int(input logic e);
        check({15'h0000, e}, {15'h0000, int_n});
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        u_host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        u_host.access(1'b0, a, 16'h0000, q);
        check(e, q);
    endtask
    // The interrupt answers two edges after the sampled pulse.
    task automatic pulse(input logic [NUM_STAGES-1:0] m);
        @(posedge clk);
        done <= m;
        @(posedge clk);
        done <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(DONE_EN_OFFSET, 16'h0000);
        rd(LOW_FLAGS_OFFSET, 16'h0000);
        ck_int(1'b1);
        rd(12'h0ff, 16'h0000);
        $display("test reset done");
        wr(DONE_EN_OFFSET, 16'h0008);
        pulse(12'h008);
        ck_int(1'b0);
        rd(DONE_STATUS_OFFSET, 16'h0008);
        @(posedge clk);
        #1 ck_int(1'b1);
        wr(DONE_EN_OFFSET, 16'hf000);
        rd(DONE_EN_OFFSET, 16'h1000);
        pulse(12'h008);
        ck_int(1'b1);
        rd(DONE_STATUS_OFFSET, 16'h0008);
        $display("test completion done");
        @(posedge clk);
        gpio <= 1'b1;
        repeat (6) @(posedge clk);
        #1 ck_int(1'b0);
        rd(DONE_STATUS_OFFSET, 16'h1000);
        @(posedge clk);
        #1 ck_int(1'b1);
        $display("test gpio done");
        wr(DONE_EN_OFFSET, 16'h0000);
        @(posedge clk);
        gpio <= 1'b0;
        repeat (6) @(posedge clk);
        #1 ck_int(1'b1);
        rd(DONE_STATUS_OFFSET, 16'h1000);
        $display("test gpio blocked done");
        @(posedge clk);
        exceed <= 12'h080;
        low_en <= 12'h080;
        pulse(12'h080);
        ck_int(1'b0);
        rd(LOW_FLAGS_OFFSET, 16'h0080);
        rd(LOW_FLAGS_OFFSET, 16'h0080);
        @(posedge clk);
        exceed <= '0;
        rd(LOW_FLAGS_OFFSET, 16'h0080);
        rd(LOW_FLAGS_OFFSET, 16'h0000);
        wr(LOW_FLAGS_OFFSET, 16'h0fff);
        rd(LOW_FLAGS_OFFSET, 16'h0000);
        ck_int(1'b1);
        $display("test low flags done");
        finish_test();
    end
    initial
    begin
        #20000;
        errors++;
        finish_test();
    end
endmodule // stage_irq_ctrl_tb_top
